/* File: fpc_pkg.sv */
/*
  Shared constants and carrier types for the flag pin and analog output configuration block.
  Assumes a single system clock.
  Registers are 16 bits wide and sit at word addresses on a plain strobe port.
*/
// Contract
// [RULE_01] analog pin drives the selected source when enabled, otherwise high impedance
// [RULE_02] gain code 00/01/10/11 selects 1.33, 2.0, 3.0, 5.33
// [RULE_03] unity override bit forces gain 1.0 regardless of gain code
// [RULE_04] output one: code 000 channel 1, 001 channel 3, 101 reference
// [RULE_05] output two: code 000 channel 2, 001 channel 4, 101 reference
// [RULE_06] output three: 000 channel 5, 001 channel 6, 101 reference, 111 supply
// [RULE_07] output two drives its pin only while its enable bit is 1
// [RULE_08] core clock divides system clock by six-bit divider value plus one
// [RULE_09] software must not rewrite the divider once cores run
// [RULE_10] divider 0 or 1 refuses code memory access; 2 or more allows read-only
// [RULE_11] divider 0 forbids core operation and flag-pin driving; 1 or more allows; code clears only mode.flag_drive_allowed, not flag_pin_oe
// [RULE_12] direction bits apply only to flags whose source connects a pin
// [RULE_13] source bit 0: pin alternate function, flag bus from internal flag
// [RULE_14] source 1, direction 0: pin and flag bus both from internal flag
// [RULE_15] source 1, direction 1: flag bus from pin; direction resets to ones
// [RULE_16] flag 4 source 0: flag 4 and 12 pins are sense 4 inputs
// [RULE_17] flag 4 source 1, flag 12 source 0: flag 12 pin is start 8
// [RULE_18] polarity bit 1 inverts flag between pin and bus; resets to zero
// [RULE_19] polarity bits also set start input level when not flags; 0 high
// [RULE_20] start polarity 1 makes the start input active low
// [RULE_21] flags 0-15 map to flag pins 0-4, start 1-8, interrupt, analog 2, debug
package fpc_pkg;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int NFLAG = 16;
  localparam int NSTART = 8;
  localparam int DIV_W = 6;

  // word addresses
  localparam logic [8:0] ADDR_AOUT1 = 9'h197;
  localparam logic [8:0] ADDR_AOUT2 = 9'h198;
  localparam logic [8:0] ADDR_AOUT3 = 9'h199;
  localparam logic [8:0] ADDR_CLKDIV = 9'h1a0;
  localparam logic [8:0] ADDR_FDIR = 9'h1a1;
  localparam logic [8:0] ADDR_FINV = 9'h1a2;

  // analog selector field layout
  localparam int AOUT_EN_POS = 0;
  localparam int AOUT_GAIN_POS = 1;
  localparam int AOUT_SRC_POS = 3;
  localparam int AOUT_UNITY_POS = 6;
  localparam logic [15:0] AOUT_MASK = 16'h007f;
  localparam logic [15:0] DIV_MASK = 16'h003f;

  // reset values
  localparam logic [15:0] RST_AOUT = 16'h0000;
  localparam logic [15:0] RST_CLKDIV = 16'h0000;
  localparam logic [15:0] RST_FDIR = 16'hffff;
  localparam logic [15:0] RST_FINV = 16'h0000;

  // source codes
  localparam logic [2:0] SRC_CODE_A = 3'h0;
  localparam logic [2:0] SRC_CODE_B = 3'h1;
  localparam logic [2:0] SRC_CODE_REF = 3'h5;
  localparam logic [2:0] SRC_CODE_SUP = 3'h7;

  // gain codes
  localparam logic [1:0] GAIN_CODE_133 = 2'h0;
  localparam logic [1:0] GAIN_CODE_200 = 2'h1;
  localparam logic [1:0] GAIN_CODE_300 = 2'h2;
  localparam logic [1:0] GAIN_CODE_533 = 2'h3;

  // divider thresholds
  localparam logic [5:0] DIV_MIN_RUN = 6'h01;
  localparam logic [5:0] DIV_MIN_CODE_READ = 6'h02;

  // flag bit positions
  localparam int FLAG_SENSE = 4;
  localparam int FLAG_START1 = 5;
  localparam int FLAG_START8 = 12;

  typedef enum logic [3:0] {
    FPC_SRC_NONE,
    FPC_SRC_CM1,
    FPC_SRC_CM2,
    FPC_SRC_CM3,
    FPC_SRC_CM4,
    FPC_SRC_CM5,
    FPC_SRC_CM6,
    FPC_SRC_REF2V5,
    FPC_SRC_VCCA
  } fpc_src_e;

  typedef enum logic [2:0] {
    FPC_GAIN_1P00,
    FPC_GAIN_1P33,
    FPC_GAIN_2P00,
    FPC_GAIN_3P00,
    FPC_GAIN_5P33
  } fpc_gain_e;

  typedef struct packed {
    logic drive_on;
    fpc_src_e source;
    fpc_gain_e gain;
  } fpc_aout_s;

  typedef struct packed {
    logic core_run_allowed;
    logic flag_drive_allowed;
    logic code_mem_read_allowed;
    logic code_mem_write_allowed;
  } fpc_mode_s;

endpackage

/* File: fpc_aout_decode.sv */
/*
  Decoder for one analog output selector register.
  Assumes the register value comes from a flip-flop on the same clock.
*/
`timescale 1ns/1ns
module fpc_aout_decode #(
  parameter fpc_pkg::fpc_src_e SRC_A = fpc_pkg::FPC_SRC_CM1, // source for code 000
  parameter fpc_pkg::fpc_src_e SRC_B = fpc_pkg::FPC_SRC_CM3, // source for code 001
  parameter bit HAS_SUPPLY = 1'b0 // code 111 routes the supply
) (
  input wire logic [15:0] cfg, // selector register value
  output fpc_pkg::fpc_aout_s aout // decoded selection
);

  wire logic [1:0] aout_gain_code = cfg[fpc_pkg::AOUT_GAIN_POS +: 2];
  wire logic [2:0] aout_source_code = cfg[fpc_pkg::AOUT_SRC_POS +: 3];
  wire logic aout_unity_override = cfg[fpc_pkg::AOUT_UNITY_POS];
  wire logic aout_drive_on = cfg[fpc_pkg::AOUT_EN_POS];
  fpc_pkg::fpc_gain_e code_gain;
  fpc_pkg::fpc_src_e src_sel;

  always_comb
  begin
    unique case (aout_gain_code) // RULE_02
      fpc_pkg::GAIN_CODE_133: code_gain = fpc_pkg::FPC_GAIN_1P33;
      fpc_pkg::GAIN_CODE_200: code_gain = fpc_pkg::FPC_GAIN_2P00;
      fpc_pkg::GAIN_CODE_300: code_gain = fpc_pkg::FPC_GAIN_3P00;
      fpc_pkg::GAIN_CODE_533: code_gain = fpc_pkg::FPC_GAIN_5P33;
    endcase
  end

  // unassigned codes route nothing rather than guess at an internal node
  always_comb
  begin
    src_sel = fpc_pkg::FPC_SRC_NONE;
    if (aout_source_code == fpc_pkg::SRC_CODE_A)
      src_sel = SRC_A; // RULE_04
    else if (aout_source_code == fpc_pkg::SRC_CODE_B)
      src_sel = SRC_B; // RULE_05
    else if (aout_source_code == fpc_pkg::SRC_CODE_REF)
      src_sel = fpc_pkg::FPC_SRC_REF2V5;
    else if (HAS_SUPPLY && aout_source_code == fpc_pkg::SRC_CODE_SUP)
      src_sel = fpc_pkg::FPC_SRC_VCCA; // RULE_06
  end

  assign aout.drive_on = aout_drive_on; // RULE_01
  assign aout.source = src_sel;
  assign aout.gain = aout_unity_override ? fpc_pkg::FPC_GAIN_1P00 : code_gain; // RULE_03

endmodule

/* File: fpc_flag_pin_config.sv */
/*
  Flag pin routing, analog output selection and core clock divider configuration.
  Assumes flag_source and int_flags come from logic on the same clock, and that
  flag pins and start pins arrive asynchronously and are synchronised here.
*/
`timescale 1ns/1ns
module fpc_flag_pin_config #(
  parameter int NFLAG = fpc_pkg::NFLAG // number of flag lanes
) (
  input wire logic clock, // system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic [8:0] reg_addr, // register word address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, valid cycle after read strobe
  input wire logic [NFLAG-1:0] flag_source, // per-flag source select
  input wire logic [NFLAG-1:0] int_flags, // internal flag values
  output logic [NFLAG-1:0] flag_bus, // flag bus toward the cores
  input wire logic [NFLAG-1:0] flag_pin_in, // pin levels, asynchronous
  output logic [NFLAG-1:0] flag_pin_out, // pin drive level
  output logic [NFLAG-1:0] flag_pin_oe, // pin drive enable
  output logic [fpc_pkg::NSTART-1:0] start_req, // start requests, active high
  output logic sense4_inputs_active, // flag 4 and 12 pins serve sense 4
  output fpc_pkg::fpc_aout_s aout1, // analog output one selection
  output fpc_pkg::fpc_aout_s aout2, // analog output two selection
  output fpc_pkg::fpc_aout_s aout3, // analog output three selection
  output logic [2:0] analog_pin_oe, // analog pin drive enables
  output logic core_tick, // one-cycle core clock enable pulse
  output fpc_pkg::fpc_mode_s mode // operating modes permitted by divider
);

  logic [15:0] aout1_ff;
  logic [15:0] aout2_ff;
  logic [15:0] aout3_ff;
  logic [15:0] clkdiv_ff;
  logic [15:0] fdir_ff;
  logic [15:0] finv_ff;
  logic [15:0] rdata_ff;
  logic [NFLAG-1:0] pin_meta_ff;
  logic [NFLAG-1:0] pin_sync_ff;
  logic [NFLAG-1:0] flag_bus_ff;
  logic [NFLAG-1:0] pin_out_ff;
  logic [NFLAG-1:0] pin_oe_ff;
  logic [fpc_pkg::NSTART-1:0] start_ff;
  logic [5:0] div_cnt_ff;
  logic tick_ff;

  // register decode
  wire logic hit_aout1 = reg_addr == fpc_pkg::ADDR_AOUT1;
  wire logic hit_aout2 = reg_addr == fpc_pkg::ADDR_AOUT2;
  wire logic hit_aout3 = reg_addr == fpc_pkg::ADDR_AOUT3;
  wire logic hit_clkdiv = reg_addr == fpc_pkg::ADDR_CLKDIV;
  wire logic hit_fdir = reg_addr == fpc_pkg::ADDR_FDIR;
  wire logic hit_finv = reg_addr == fpc_pkg::ADDR_FINV;
  wire logic [15:0] wdata_aout = reg_wdata & fpc_pkg::AOUT_MASK;
  wire logic [15:0] wdata_div = reg_wdata & fpc_pkg::DIV_MASK;

  // unmapped addresses read as zero
  wire logic [15:0] nxt_rdata =
    hit_aout1 ? aout1_ff :
    hit_aout2 ? aout2_ff :
    hit_aout3 ? aout3_ff :
    hit_clkdiv ? clkdiv_ff :
    hit_fdir ? fdir_ff :
    hit_finv ? finv_ff : 16'h0000;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      aout1_ff <= fpc_pkg::RST_AOUT;
      aout2_ff <= fpc_pkg::RST_AOUT;
      aout3_ff <= fpc_pkg::RST_AOUT;
      clkdiv_ff <= fpc_pkg::RST_CLKDIV;
      fdir_ff <= fpc_pkg::RST_FDIR; // RULE_15
      finv_ff <= fpc_pkg::RST_FINV; // RULE_18
    end
    else if (reg_wr)
    begin
      if (hit_aout1)
        aout1_ff <= wdata_aout;
      if (hit_aout2)
        aout2_ff <= wdata_aout;
      if (hit_aout3)
        aout3_ff <= wdata_aout;
      // a rewrite while cores run is accepted; keeping it stable is software's job
      if (hit_clkdiv)
        clkdiv_ff <= wdata_div; // RULE_09
      if (hit_fdir)
        fdir_ff <= reg_wdata;
      if (hit_finv)
        finv_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      rdata_ff <= 16'h0000;
    else if (reg_rd)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= 16'h0000;
  end

  assign reg_rdata = rdata_ff;

  // analog outputs
  fpc_aout_decode #(
    .SRC_A(fpc_pkg::FPC_SRC_CM1),
    .SRC_B(fpc_pkg::FPC_SRC_CM3),
    .HAS_SUPPLY(1'b0)
  ) u_aout1 (
    .cfg(aout1_ff),
    .aout(aout1)
  );

  fpc_aout_decode #(
    .SRC_A(fpc_pkg::FPC_SRC_CM2),
    .SRC_B(fpc_pkg::FPC_SRC_CM4),
    .HAS_SUPPLY(1'b0)
  ) u_aout2 (
    .cfg(aout2_ff),
    .aout(aout2)
  );

  fpc_aout_decode #(
    .SRC_A(fpc_pkg::FPC_SRC_CM5),
    .SRC_B(fpc_pkg::FPC_SRC_CM6),
    .HAS_SUPPLY(1'b1)
  ) u_aout3 (
    .cfg(aout3_ff),
    .aout(aout3)
  );

  // disabled pins float so all three can share one converter input
  assign analog_pin_oe[0] = aout1.drive_on; // RULE_01
  assign analog_pin_oe[1] = aout2.drive_on; // RULE_07
  assign analog_pin_oe[2] = aout3.drive_on; // RULE_01

  // core clock divider
  wire logic [5:0] core_divide_value = clkdiv_ff[5:0];
  wire logic div_wrap = div_cnt_ff >= core_divide_value;
  wire logic [5:0] nxt_div_cnt = div_wrap ? 6'h00 : 6'(div_cnt_ff + 6'h01);

  // a tick every value+1 cycles, none at value 0; counter restarts cleanly if the value shrinks
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      div_cnt_ff <= 6'h00;
      tick_ff <= 1'b0;
    end
    else
    begin
      div_cnt_ff <= nxt_div_cnt; // RULE_08
      tick_ff <= div_wrap && mode.core_run_allowed; // RULE_08
    end
  end

  assign core_tick = tick_ff;
  assign mode.core_run_allowed = core_divide_value >= fpc_pkg::DIV_MIN_RUN; // RULE_11
  assign mode.flag_drive_allowed = core_divide_value >= fpc_pkg::DIV_MIN_RUN; // RULE_11
  assign mode.code_mem_read_allowed = core_divide_value >= fpc_pkg::DIV_MIN_CODE_READ; // RULE_10
  assign mode.code_mem_write_allowed = 1'b0; // RULE_10

  // pin synchroniser
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end
    else
    begin
      pin_meta_ff <= flag_pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // flag routing
  // flag 4 source low turns both flag 4 and flag 12 pins into sense inputs
  wire logic sense4_mode = !flag_source[fpc_pkg::FLAG_SENSE]; // RULE_16
  logic [NFLAG-1:0] pin_is_flag;
  logic [NFLAG-1:0] pin_is_input;
  logic [NFLAG-1:0] nxt_flag_bus;
  logic [NFLAG-1:0] nxt_pin_out;
  logic [NFLAG-1:0] nxt_pin_oe;

  always_comb
  begin
    pin_is_flag = flag_source; // RULE_21
    if (sense4_mode)
      pin_is_flag[fpc_pkg::FLAG_START8] = 1'b0; // RULE_16
    pin_is_input = pin_is_flag & fdir_ff; // RULE_12
  end

  always_comb
  begin
    for (int i = 0; i < NFLAG; i++)
    begin
      if (pin_is_input[i])
        nxt_flag_bus[i] = pin_sync_ff[i] ^ finv_ff[i]; // RULE_15 RULE_18
      else
        nxt_flag_bus[i] = int_flags[i]; // RULE_13 RULE_14
    end
    nxt_pin_out = int_flags ^ finv_ff; // RULE_14 RULE_18
    nxt_pin_oe = pin_is_flag & ~fdir_ff; // RULE_12 RULE_14
  end

  // start inputs sit on flags 5..12; flag 12 is start 8 only outside sense mode
  logic [fpc_pkg::NSTART-1:0] nxt_start;
  always_comb
  begin
    for (int s = 0; s < fpc_pkg::NSTART; s++)
    begin
      // polarity 1 means active low, so the level is inverted
      nxt_start[s] = !pin_is_flag[fpc_pkg::FLAG_START1 + s] &&
        (pin_sync_ff[fpc_pkg::FLAG_START1 + s] ^ finv_ff[fpc_pkg::FLAG_START1 + s]); // RULE_19 RULE_20
    end
    if (sense4_mode)
      nxt_start[fpc_pkg::NSTART-1] = 1'b0; // RULE_17
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      flag_bus_ff <= '0;
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
      start_ff <= '0;
    end
    else
    begin
      flag_bus_ff <= nxt_flag_bus;
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      start_ff <= nxt_start;
    end
  end

  assign flag_bus = flag_bus_ff;
  assign flag_pin_out = pin_out_ff;
  assign flag_pin_oe = pin_oe_ff;
  assign start_req = start_ff;
  assign sense4_inputs_active = sense4_mode; // RULE_16

endmodule

/* File: fpc_flag_pin_config_sva.sv */
/*
  Checker for the flag pin configuration block.
  Sees only top ports; bound to every instance at the foot of this file.
*/
`timescale 1ns/1ns
module fpc_flag_pin_config_sva #(
  parameter int NFLAG = 16 // flag lanes
) (
  input wire logic clock, // system clock
  input wire logic srst, // sync reset
  input wire logic [8:0] reg_addr, // address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [15:0] reg_rdata, // read data
  input wire logic [NFLAG-1:0] flag_source, // source select
  input wire logic [NFLAG-1:0] int_flags, // internal flags
  input wire logic [NFLAG-1:0] flag_bus, // flag bus
  input wire logic [NFLAG-1:0] flag_pin_oe, // pin enables
  input wire logic sense4_inputs_active, // sense pins
  input fpc_pkg::fpc_aout_s aout1, // output one
  input fpc_pkg::fpc_aout_s aout2, // output two
  input fpc_pkg::fpc_aout_s aout3, // output three
  input wire logic [2:0] analog_pin_oe, // analog enables
  input fpc_pkg::fpc_mode_s mode // mode flags
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  property p_rd_quiet;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
  property p_aout2_oe;
    reg_wr && reg_addr == fpc_pkg::ADDR_AOUT2 |=> analog_pin_oe[1] == $past(reg_wdata[0]);
  endproperty
  a_aout2_oe: assert property (p_aout2_oe) else $error("output two enable wrong");
  property p_unity;
    reg_wr && reg_addr == fpc_pkg::ADDR_AOUT1 && reg_wdata[6] |=> aout1.gain == fpc_pkg::FPC_GAIN_1P00;
  endproperty
  a_unity: assert property (p_unity) else $error("unity override ignored");
  property p_gain;
    reg_wr && reg_addr == fpc_pkg::ADDR_AOUT2 && !reg_wdata[6] && reg_wdata[2:1] == 2'h3
      |=> aout2.gain == fpc_pkg::FPC_GAIN_5P33;
  endproperty
  a_gain: assert property (p_gain) else $error("gain code decode wrong");
  property p_supply;
    reg_wr && reg_addr == fpc_pkg::ADDR_AOUT3 && reg_wdata[5:3] == 3'h7 |=> aout3.source == fpc_pkg::FPC_SRC_VCCA;
  endproperty
  a_supply: assert property (p_supply) else $error("supply source not routed");
  property p_sense4;
    !flag_source[4] |=> !flag_pin_oe[4] && !flag_pin_oe[12] && $past(sense4_inputs_active);
  endproperty
  a_sense4: assert property (p_sense4) else $error("sense pins driven");
  property p_nonflag;
    1'b1 |=> ((flag_bus ^ $past(int_flags)) & ~$past(flag_source)) == '0;
  endproperty
  a_nonflag: assert property (p_nonflag) else $error("non-flag bus bit wrong");
  property p_outflag;
    1'b1 |=> ((flag_bus ^ $past(int_flags)) & flag_pin_oe) == '0;
  endproperty
  a_outflag: assert property (p_outflag) else $error("output flag bus bit wrong");
  property p_oe_src;
    1'b1 |=> (flag_pin_oe & ~$past(flag_source)) == '0;
  endproperty
  a_oe_src: assert property (p_oe_src) else $error("pin driven without source");
  property p_div_mode;
    reg_wr && reg_addr == fpc_pkg::ADDR_CLKDIV |=> mode.flag_drive_allowed == ($past(reg_wdata[5:0]) != 6'h00)
      && mode.code_mem_read_allowed == ($past(reg_wdata[5:0]) > 6'h01);
  endproperty
  a_div_mode: assert property (p_div_mode) else $error("divider modes wrong");
endmodule
bind fpc_flag_pin_config fpc_flag_pin_config_sva #(.NFLAG(NFLAG)) i_fpc_flag_pin_config_sva (.clock, .srst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flag_source, .int_flags, .flag_bus, .flag_pin_oe,
  .sense4_inputs_active, .aout1, .aout2, .aout3, .analog_pin_oe, .mode);

/* File: fpc_host_model.sv */
/*
  Host side of the flag pins: presents its own levels and resolves each wire.
  Assumes the device raises its enable only on pins it drives.
*/
`timescale 1ns/1ns
module fpc_host_model (
  input wire logic clock, // system clock
  input wire logic [15:0] drive_lvl, // levels the host presents
  input wire logic [15:0] dev_oe, // device enables
  input wire logic [15:0] dev_out, // device levels
  output logic [15:0] pin // wire level
);
  logic [15:0] lvl_ff;
  // host lags a cycle, like firmware writing a port
  always_ff @(posedge clock)
    lvl_ff <= drive_lvl;
  assign pin = (dev_oe & dev_out) | (~dev_oe & lvl_ff);
endmodule

/* File: fpc_flag_pin_config_test.sv */
/*
  Self-checking bench for the flag pin configuration block.
  Assumes the host model resolves pins; read data are checked off a queue.
*/
`timescale 1ns/1ns
module fpc_flag_pin_config_test;
  logic clock = 0, srst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0, sense4, core_tick;
  logic [8:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, reg_rdata, flag_source = '0, int_flags = '0, host_lvl = '0, pins;
  logic [15:0] flag_bus, pin_out, pin_oe, exp_q[$];
  logic [7:0] start_req;
  logic [2:0] aoe;
  fpc_pkg::fpc_aout_s aout1, aout2, aout3;
  fpc_pkg::fpc_mode_s mode;
  int error_cnt = 0, total_checks = 0, dv[5] = '{0, 1, 2, 4, 63};
  logic [8:0] addrs[6] = '{fpc_pkg::ADDR_AOUT1, fpc_pkg::ADDR_AOUT2, fpc_pkg::ADDR_AOUT3, fpc_pkg::ADDR_CLKDIV,
    fpc_pkg::ADDR_FDIR, fpc_pkg::ADDR_FINV};
  logic [15:0] msk[6] = '{fpc_pkg::AOUT_MASK, fpc_pkg::AOUT_MASK, fpc_pkg::AOUT_MASK, fpc_pkg::DIV_MASK,
    16'hffff, 16'hffff};
  fpc_pkg::fpc_gain_e gt[4] = '{fpc_pkg::FPC_GAIN_1P33, fpc_pkg::FPC_GAIN_2P00, fpc_pkg::FPC_GAIN_3P00,
    fpc_pkg::FPC_GAIN_5P33};
  fpc_flag_pin_config i_fpc_flag_pin_config (.clock, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .flag_source, .int_flags, .flag_bus, .flag_pin_in(pins), .flag_pin_out(pin_out), .flag_pin_oe(pin_oe),
    .start_req, .sense4_inputs_active(sense4), .aout1, .aout2, .aout3, .analog_pin_oe(aoe), .core_tick, .mode);
  fpc_host_model i_fpc_host_model (.clock, .drive_lvl(host_lvl), .dev_oe(pin_oe), .dev_out(pin_out), .pin(pins));
  initial
    forever #50 clock = ~clock;
  function automatic fpc_pkg::fpc_src_e esrc(int k, logic [2:0] c);
    fpc_pkg::fpc_src_e t[3][2] = '{'{fpc_pkg::FPC_SRC_CM1, fpc_pkg::FPC_SRC_CM3},
      '{fpc_pkg::FPC_SRC_CM2, fpc_pkg::FPC_SRC_CM4}, '{fpc_pkg::FPC_SRC_CM5, fpc_pkg::FPC_SRC_CM6}};
    if (c < 3'h2)
      return t[k][c[0]];
    if (c == 3'h5)
      return fpc_pkg::FPC_SRC_REF2V5;
    if (c == 3'h7 && k == 2)
      return fpc_pkg::FPC_SRC_VCCA;
    return fpc_pkg::FPC_SRC_NONE;
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [8:0] a, logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [8:0] a, logic [15:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask
  // read data stand only in the slot after the strobe
  always @(posedge clock)
  begin
    rd_d <= reg_rd;
    if (rd_d)
      chk("rdata", exp_q.pop_front(), reg_rdata);
  end
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #3000000;
    error_cnt++;
    close_out();
  end
  initial
  begin
    logic [15:0] d, dir, pol, ebus, eoe;
    logic [7:0] est;
    logic nf;
    fpc_pkg::fpc_aout_s ea;
    int n;
    void'($urandom(32'h2aea_6c5d));
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    rd(fpc_pkg::ADDR_FDIR, 16'hffff);
    rd(fpc_pkg::ADDR_FINV, 16'h0000);
    rd(fpc_pkg::ADDR_CLKDIV, 16'h0000);
    wr(9'h1a3, 16'(~$urandom));
    rd(9'h1a3, 16'h0000);
    foreach (addrs[i])
    begin
      d = 16'($urandom);
      wr(addrs[i], d);
      rd(addrs[i], d & msk[i]);
    end
    for (int k = 0; k < 3; k++)
      for (int c = 0; c < 128; c++)
      begin
        wr(addrs[k], 16'(c));
        #1;
        ea = '{c[0], esrc(k, c[5:3]), c[6] ? fpc_pkg::FPC_GAIN_1P00 : gt[c[2:1]]};
        chk("aout", 16'(ea), 16'(k == 0 ? aout1 : k == 1 ? aout2 : aout3));
        chk("aoe", 16'(c[0]), 16'(aoe[k]));
      end
    foreach (dv[i])
    begin
      // no core is modelled here, so each divider value is set while the cores are idle
      wr(fpc_pkg::ADDR_CLKDIV, 16'(dv[i]));
      #1;
      chk("mode", 16'({dv[i] > 0, dv[i] > 0, dv[i] > 1, 1'b0}), 16'(mode));
      n = 0;
      repeat (2) @(posedge clock);
      repeat ((dv[i] + 1) * 4)
      begin
        @(posedge clock);
        n += int'(core_tick);
      end
      chk("ticks", 16'(dv[i] ? 4 : 0), 16'(n));
    end
    repeat (60)
    begin
      dir = 16'($urandom);
      pol = 16'($urandom);
      wr(fpc_pkg::ADDR_FDIR, dir);
      wr(fpc_pkg::ADDR_FINV, pol);
      @(posedge clock);
      flag_source <= 16'($urandom);
      int_flags <= 16'($urandom);
      host_lvl <= 16'($urandom);
      repeat (5) @(posedge clock);
      #1;
      for (int i = 0; i < 16; i++)
      begin
        nf = !flag_source[i] || (i == 12 && !flag_source[4]);
        eoe[i] = !nf && !dir[i];
        ebus[i] = (nf || !dir[i]) ? int_flags[i] : host_lvl[i] ^ pol[i];
        if (i >= 5 && i <= 12)
          est[i-5] = nf && !(i == 12 && !flag_source[4]) && (host_lvl[i] ^ pol[i]);
      end
      chk("bus", ebus, flag_bus);
      chk("oe", eoe, pin_oe);
      chk("out", (int_flags ^ pol) & eoe, pin_out & eoe);
      chk("start", 16'(est), 16'(start_req));
      chk("sense", 16'(!flag_source[4]), 16'(sense4));
    end
    close_out();
  end
endmodule
